// [core/aem_pkg.sv]
`default_nettype none
package aem_pkg;
    // register port geometry
    localparam int          AEM_ADDR_W      = 8;
    localparam int          AEM_MASK_W      = 24;
    localparam logic [7:0]  AEM_REG_ALERT_EN = 8'h49;

    // mask field positions
    localparam int          AEM_OC_HI       = 23;
    localparam int          AEM_UC_HI       = 19;
    localparam int          AEM_OV_HI       = 15;
    localparam int          AEM_UV_HI       = 11;
    localparam int          AEM_OP_HI       = 7;
    localparam int          AEM_OP_LO       = 4;
    localparam int          AEM_ACCUMULATOR_FULL_ALERT_EN_BIT = 3;
    localparam int          AEM_ACC_CNT_BIT = 2;
    localparam int          AEM_CC_BIT      = 1;
    localparam int          AEM_RSVD_BIT    = 0;

    // limit sources: 5 kinds by 4 channels, mask bits 23..4
    localparam int          AEM_N_CH        = 4;
    localparam int          AEM_N_LIMIT     = 20;
    localparam int          AEM_NSEL_W      = 2;

    // reset and writable patterns
    localparam logic [23:0] AEM_MASK_RESET  = 24'h000000;
    localparam logic [23:0] AEM_MASK_WRITE  = 24'hFFFFFE;
    localparam logic [23:0] AEM_READ_ZERO   = 24'h000000;

    // consecutive-sample selections
    localparam logic [1:0]  AEM_NS_1        = 2'h0;
    localparam logic [1:0]  AEM_NS_4        = 2'h1;
    localparam logic [1:0]  AEM_NS_8        = 2'h2;
    localparam int          AEM_CNT_W       = 5;
    localparam logic [4:0]  AEM_CNT_1       = 5'h01;
    localparam logic [4:0]  AEM_CNT_4       = 5'h04;
    localparam logic [4:0]  AEM_CNT_8       = 5'h08;
    localparam logic [4:0]  AEM_CNT_16      = 5'h10;
    localparam logic [4:0]  AEM_CNT_ZERO    = 5'h00;
    localparam logic [4:0]  AEM_CNT_ONE     = 5'h01;

    // refresh sequencing
    typedef enum logic [0:0] {
        AEM_ST_IDLE = 1'b0,
        AEM_ST_LOAD = 1'b1
    } aem_state_type;

    // selection code to required consecutive samples
    function automatic logic [4:0] aem_need_count(input logic [1:0] sel);
        logic [4:0] need;
        need = AEM_CNT_16;
        case (sel)
            AEM_NS_1: need = AEM_CNT_1;
            AEM_NS_4: need = AEM_CNT_4;
            AEM_NS_8: need = AEM_CNT_8;
            default:  need = AEM_CNT_16;
        endcase
        return need;
    endfunction
endpackage
`default_nettype wire

// [core/aem_src_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface aem_src_if #(
    parameter int N_SRC  = 20,
    parameter int NSEL_W = 2
);
    logic                      sample_stb;
    logic [N_SRC-1:0]          beyond;
    logic [N_SRC*NSEL_W-1:0]   nsel;
    logic [N_SRC-1:0]          fired;

    // mask side drives raw conditions, receives qualified ones
    modport owner (
        output sample_stb,
        output beyond,
        output nsel,
        input  fired
    );
    modport counter (
        input  sample_stb,
        input  beyond,
        input  nsel,
        output fired
    );
endinterface
`default_nettype wire

// [core/aem_persist.sv]
`timescale 1ns/10ps
`default_nettype none
module aem_persist
    import aem_pkg::*;
#(
    parameter int N_SRC = AEM_N_LIMIT,
    parameter int CNT_W = AEM_CNT_W
) (
    // clocking
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    input  wire logic  clk_en,
    // source conditions
    aem_src_if.counter src
);
    generate
        if (CNT_W < AEM_CNT_W) begin : g_bad_width
            $error("aem_persist: CNT_W too small for sixteen samples");
        end
    endgenerate

    logic [CNT_W-1:0] run_ff  [N_SRC];
    logic [CNT_W-1:0] nxt_run [N_SRC];
    logic [N_SRC-1:0] fired_ff;
    logic [N_SRC-1:0] nxt_fired;

    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++) begin : g_src
            logic [CNT_W-1:0] need;
            assign need = CNT_W'(aem_need_count(src.nsel[gi*AEM_NSEL_W +: AEM_NSEL_W]));

            // consecutive-sample run length, saturating at the need
            always_comb begin
                nxt_run[gi] = run_ff[gi];
                if (src.sample_stb) begin
                    if (!src.beyond[gi]) begin
                        nxt_run[gi] = CNT_W'(AEM_CNT_ZERO);
                    end else if (run_ff[gi] < need) begin
                        nxt_run[gi] = run_ff[gi] + CNT_W'(AEM_CNT_ONE);
                    end
                end
                nxt_fired[gi] = (nxt_run[gi] >= need);
            end

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    run_ff[gi] <= CNT_W'(AEM_CNT_ZERO);
                end else if (clk_en) begin
                    run_ff[gi] <= nxt_run[gi];
                end
            end

            // a source fires only with the full run behind it
            AST_PERSIST_RUN: assert property (@(posedge core_clk) disable iff (sys_rst)
                fired_ff[gi] |-> run_ff[gi] >= need)
                else $error("source fired before its sample run was complete");
        end
    endgenerate

    // qualified condition register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fired_ff <= '0;
        end else if (clk_en) begin
            fired_ff <= nxt_fired;
        end
    end

    assign src.fired = fired_ff;
endmodule
`default_nettype wire

// [core/aem_top.sv]
// Overview of operation
// - writing one to an enable bit enables that alert; zero leaves it disabled.
// - a source reaches the alert pin only when its active enable is set.
// - written enables stay inactive until any refresh command arrives.
// - bits 23..20 enable overcurrent alerts of channels 1..4.
// - bits 19..16 enable undercurrent alerts of channels 1..4.
// - bits 15..12 enable overvoltage alerts of channels 1..4.
// - bits 11..8 enable undervoltage alerts of channels 1..4.
// - bits 7..4 enable overpower alerts of channels 1..4.
// - bit 3 enables one shared alert for any accumulator past fullness.
// - bit 2 governs the sample-counter fullness alert; zero disables it.
// - bit 1 enables an alert on each conversion cycle completion.
// - bit 0 reads zero and ignores writes.
// - limit alerts need 1, 4, 8 or 16 consecutive beyond-limit samples.
`timescale 1ns/10ps
`default_nettype none
module aem_top
    import aem_pkg::*;
(
    // clocking
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    // register port
    input  wire logic [AEM_ADDR_W-1:0]       reg_addr,
    input  wire logic [AEM_MASK_W-1:0]       reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [AEM_MASK_W-1:0]       reg_rdata,
    output logic                             reg_rvalid,
    // refresh command, any variant
    input  wire logic                        refresh_cmd,
    // alert sources
    input  wire logic                        sample_stb,
    input  wire logic [AEM_N_LIMIT-1:0]      limit_beyond,
    input  wire logic [AEM_N_LIMIT*AEM_NSEL_W-1:0] limit_nsel,
    input  wire logic                        acc_full_evt,
    input  wire logic                        count_full_evt,
    input  wire logic                        cycle_done_evt,
    // results
    output logic                             alert_out,
    output logic      [AEM_MASK_W-1:0]       active_mask
);
    aem_state_type             state_ff;
    aem_state_type             nxt_state;
    logic [AEM_MASK_W-1:0]     pend_ff;
    logic [AEM_MASK_W-1:0]     nxt_pend;
    logic [AEM_MASK_W-1:0]     shadow_ff;
    logic [AEM_MASK_W-1:0]     nxt_shadow;
    logic [AEM_MASK_W-1:0]     rdata_ff;
    logic [AEM_MASK_W-1:0]     nxt_rdata;
    logic                      rvalid_ff;
    logic                      nxt_rvalid;
    logic                      alert_ff;
    logic                      nxt_alert;
    logic [AEM_MASK_W-1:0]     src_vec;
    logic                      hit_mask;

    aem_src_if #(.N_SRC(AEM_N_LIMIT), .NSEL_W(AEM_NSEL_W)) src_bus ();

    // address decode shared by read and write
    function automatic logic is_mask_reg(input logic [AEM_ADDR_W-1:0] a);
        return a == AEM_REG_ALERT_EN;
    endfunction

    assign hit_mask = is_mask_reg(reg_addr);

    // raw conditions to the persistence counters
    assign src_bus.sample_stb = sample_stb;
    assign src_bus.beyond     = limit_beyond;
    assign src_bus.nsel       = limit_nsel;

    aem_persist #(
        .N_SRC (AEM_N_LIMIT),
        .CNT_W (AEM_CNT_W)
    ) u_persist (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .src      (src_bus.counter)
    );

    // sources laid out on the mask bit positions
    always_comb begin
        src_vec = '0;
        src_vec[AEM_OC_HI -: AEM_N_CH] = src_bus.fired[AEM_OC_HI-AEM_OP_LO -: AEM_N_CH];
        src_vec[AEM_UC_HI -: AEM_N_CH] = src_bus.fired[AEM_UC_HI-AEM_OP_LO -: AEM_N_CH];
        src_vec[AEM_OV_HI -: AEM_N_CH] = src_bus.fired[AEM_OV_HI-AEM_OP_LO -: AEM_N_CH];
        src_vec[AEM_UV_HI -: AEM_N_CH] = src_bus.fired[AEM_UV_HI-AEM_OP_LO -: AEM_N_CH];
        src_vec[AEM_OP_HI -: AEM_N_CH] = src_bus.fired[AEM_OP_HI-AEM_OP_LO -: AEM_N_CH];
        src_vec[AEM_ACCUMULATOR_FULL_ALERT_EN_BIT]       = acc_full_evt;
        src_vec[AEM_ACC_CNT_BIT]       = count_full_evt;
        src_vec[AEM_CC_BIT]            = cycle_done_evt;
        src_vec[AEM_RSVD_BIT]          = 1'b0;
    end

    // register port and refresh sequencing
    always_comb begin
        nxt_pend   = pend_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_state  = state_ff;
        nxt_shadow = shadow_ff;
        if (reg_wr && hit_mask) begin
            nxt_pend = reg_wdata & AEM_MASK_WRITE;
        end
        if (reg_rd) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = hit_mask ? pend_ff : AEM_READ_ZERO;
        end
        case (state_ff)
            AEM_ST_IDLE: begin
                if (refresh_cmd) begin
                    nxt_state = AEM_ST_LOAD;
                end
            end
            AEM_ST_LOAD: begin
                nxt_shadow = pend_ff;
                nxt_state  = refresh_cmd ? AEM_ST_LOAD : AEM_ST_IDLE;
            end
            default: begin
                nxt_state = AEM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_ff   <= AEM_MASK_RESET;
            rdata_ff  <= AEM_READ_ZERO;
            rvalid_ff <= 1'b0;
            state_ff  <= AEM_ST_IDLE;
            shadow_ff <= AEM_MASK_RESET;
        end else if (clk_en) begin
            pend_ff   <= nxt_pend;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            state_ff  <= nxt_state;
            shadow_ff <= nxt_shadow;
        end
    end

    // alert gating through the active copy only
    always_comb begin
        nxt_alert = |(src_vec & shadow_ff);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            alert_ff <= 1'b0;
        end else if (clk_en) begin
            alert_ff <= nxt_alert;
        end
    end

    assign alert_out   = alert_ff;
    assign active_mask = shadow_ff;
    assign reg_rdata   = rdata_ff;
    assign reg_rvalid  = rvalid_ff;

    // refresh steps: request taken, then shadow loaded
    sequence s_refresh_taken;
        clk_en && refresh_cmd && state_ff == AEM_ST_IDLE;
    endsequence

    sequence s_load_step;
        state_ff == AEM_ST_LOAD;
    endsequence

    sequence s_load_enabled;
        clk_en && state_ff == AEM_ST_LOAD;
    endsequence

    AST_REFRESH_SEQ: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_refresh_taken |=> s_load_step)
        else $error("refresh did not enter the load step");

    AST_SHADOW_ONLY_ON_REFRESH: assert property (@(posedge core_clk) disable iff (sys_rst)
        !$stable(shadow_ff) |-> $past(state_ff) == AEM_ST_LOAD || $past(sys_rst))
        else $error("active mask changed without a refresh");

    AST_SHADOW_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state_ff == AEM_ST_LOAD |=> shadow_ff == $past(pend_ff))
        else $error("active mask not loaded from pending value");

    AST_WRITE_STORES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && reg_wr && hit_mask |=> pend_ff == ($past(reg_wdata) & AEM_MASK_WRITE))
        else $error("written enable value not stored");

    AST_BIT0_READS_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        reg_rvalid |-> !reg_rdata[AEM_RSVD_BIT] && !active_mask[AEM_RSVD_BIT])
        else $error("reserved bit read back as one");

    AST_NO_DISABLED_ALERT: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(alert_out) |-> $past(|(src_vec & shadow_ff)))
        else $error("alert raised by a disabled source");

    AST_OC_CH1_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OC_HI] && src_bus.fired[AEM_OC_HI-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 1 overcurrent did not alert");

    AST_ACC_FULL_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_ACCUMULATOR_FULL_ALERT_EN_BIT] && acc_full_evt |=> alert_out)
        else $error("enabled accumulator fullness did not alert");

    AST_COUNT_FULL_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_ACC_CNT_BIT] && count_full_evt |=> alert_out)
        else $error("enabled sample counter fullness did not alert");

    AST_CYCLE_DONE_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_CC_BIT] && cycle_done_evt |=> alert_out)
        else $error("enabled conversion completion did not alert");

    AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && reg_rd && hit_mask |=> reg_rvalid && reg_rdata == $past(pend_ff))
        else $error("read of the mask returned a wrong value");

    AST_UC_CH1_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_UC_HI] && src_bus.fired[AEM_UC_HI-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 1 undercurrent did not alert");

    AST_OV_CH1_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OV_HI] && src_bus.fired[AEM_OV_HI-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 1 overvoltage did not alert");

    AST_UV_CH1_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_UV_HI] && src_bus.fired[AEM_UV_HI-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 1 undervoltage did not alert");

    AST_OP_CH1_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OP_HI] && src_bus.fired[AEM_OP_HI-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 1 overpower did not alert");

    AST_OC_CH4_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_UC_HI+1] && src_bus.fired[AEM_UC_HI+1-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 4 overcurrent did not alert");

    AST_UC_CH4_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OV_HI+1] && src_bus.fired[AEM_OV_HI+1-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 4 undercurrent did not alert");

    AST_OV_CH4_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_UV_HI+1] && src_bus.fired[AEM_UV_HI+1-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 4 overvoltage did not alert");

    AST_UV_CH4_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OP_HI+1] && src_bus.fired[AEM_OP_HI+1-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 4 undervoltage did not alert");

    AST_OP_CH4_PASSES: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && shadow_ff[AEM_OP_LO] && src_bus.fired[AEM_OP_LO-AEM_OP_LO] |=> alert_out)
        else $error("enabled channel 4 overpower did not alert");

    AST_SILENT_WHEN_MASKED: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !(|(src_vec & shadow_ff)) |=> !alert_out)
        else $error("alert raised with no enabled source");

    AST_COUNT_FULL_MASKED: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && count_full_evt && !shadow_ff[AEM_ACC_CNT_BIT] && !(|(src_vec & shadow_ff)) |=> !alert_out)
        else $error("disabled sample counter fullness raised an alert");

    AST_PEND_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(clk_en && reg_wr && hit_mask) |=> $stable(pend_ff))
        else $error("pending mask changed without a write");

    AST_SHADOW_FROZEN: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> $stable(active_mask))
        else $error("active mask moved while clock enable was low");

    AST_RVALID_PULSE: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !reg_rd |=> !reg_rvalid)
        else $error("read answer strobe without a read");

    AST_RDATA_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    AST_OTHER_ADDR_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && reg_rd && !hit_mask |=> reg_rdata == AEM_READ_ZERO)
        else $error("read of another address did not answer zero");

    AST_IDLE_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state_ff == AEM_ST_IDLE && !refresh_cmd |=> state_ff == AEM_ST_IDLE)
        else $error("load step entered without a refresh");

    AST_LOAD_ENDS: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state_ff == AEM_ST_LOAD && !refresh_cmd |=> state_ff == AEM_ST_IDLE)
        else $error("load step did not end");

    AST_LOAD_REPEATS: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && state_ff == AEM_ST_LOAD && refresh_cmd |=> s_load_step)
        else $error("refresh during load step was dropped");

    AST_REFRESH_TWO_EDGES: assert property (@(posedge core_clk) disable iff (sys_rst)
        s_refresh_taken ##1 s_load_enabled |=> active_mask == $past(pend_ff))
        else $error("refresh did not apply the pending mask in two edges");

    AST_RESET_CLEARS: assert property (@(posedge core_clk)
        sys_rst |=> active_mask == AEM_MASK_RESET && pend_ff == AEM_MASK_RESET && !alert_out && !reg_rvalid)
        else $error("reset left state behind");
endmodule
`default_nettype wire

// [bench/aem_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// host side of the register port and refresh line
module aem_host_model
    import aem_pkg::*;
(
    // clocking
    input  wire logic        core_clk,
    // register port
    output logic [7:0]       reg_addr,
    output logic [23:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [23:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // refresh
    output logic             refresh_cmd
);
    // idle levels at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        refresh_cmd = 1'b0;
    end
    // one write strobe, data scrambled once taken
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // one read strobe, answer taken after the edge
    task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rvalid;
        d = reg_rdata;
    endtask
    // refresh pulse, any variant
    task automatic refresh();
        refresh_cmd = 1'b1;
        @(posedge core_clk);
        #1;
        refresh_cmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import aem_pkg::*;
    // clocking and stimulus
    logic        core_clk        = 1'b0;
    logic        sys_rst         = 1'b1;
    logic        clk_en          = 1'b1;
    logic        sample_stb      = 1'b0;
    logic [19:0] limit_beyond    = 20'h00000;
    logic [39:0] limit_nsel      = 40'h0000000000;
    logic        acc_full_evt    = 1'b0;
    logic        count_full_evt  = 1'b0;
    logic        cycle_done_evt  = 1'b0;
    // register port and results
    logic [7:0]  reg_addr;
    logic [23:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        refresh_cmd;
    logic [23:0] reg_rdata;
    logic        reg_rvalid;
    logic        alert_out;
    logic [23:0] active_mask;
    // bookkeeping
    int          n_fail          = 0;
    int          samples_checked = 0;
    int          need_t [4]      = '{1, 4, 8, 16};

    always #20 core_clk = ~core_clk;

    aem_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .refresh_cmd(refresh_cmd),
        .sample_stb(sample_stb), .limit_beyond(limit_beyond), .limit_nsel(limit_nsel),
        .acc_full_evt(acc_full_evt), .count_full_evt(count_full_evt),
        .cycle_done_evt(cycle_done_evt), .alert_out(alert_out), .active_mask(active_mask));

    aem_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .refresh_cmd(refresh_cmd));

    // verdict and end of run
    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // settle just past the next edges
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // compare and count
    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_al(input logic e);
        check("alert_out", {23'h000000, alert_out}, {23'h000000, e});
    endtask
    // read with answer strobe check
    task automatic rdchk(input logic [7:0] a, input logic [23:0] e);
        logic [23:0] d;
        logic        v;
        host.rd(a, d, v);
        check("reg_rvalid", {23'h000000, v}, 24'h000001);
        check("reg_rdata", d, e);
    endtask
    // source levels, one sample strobe, then settle
    task automatic drive(input logic [23:0] s);
        limit_beyond = s[23:4];
        acc_full_evt = s[3];
        count_full_evt = s[2];
        cycle_done_evt = s[1];
        sample_stb = 1'b1;
        step(1);
        sample_stb = 1'b0;
        step(3);
    endtask
    // write, refresh, confirm active copy two edges on
    task automatic load(input logic [23:0] m);
        host.wr(AEM_REG_ALERT_EN, m);
        step(1);
        host.refresh();
        step(1);
        check("active_mask", active_mask, m & AEM_MASK_WRITE);
    endtask

    // hang guard, well past the expected run length
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    // main sequence
    initial begin
        step(10);
        sys_rst = 1'b0;
        rdchk(AEM_REG_ALERT_EN, AEM_MASK_RESET);
        check("active_mask", active_mask, AEM_MASK_RESET);
        chk_al(1'b0);
        // each enable alone: others silent, its own source heard
        for (int b = 23; b >= 1; b--) begin
            step(1);
            load(24'h000001 << b);
            drive(~(24'h000001 << b));
            chk_al(1'b0);
            drive(24'h000001 << b);
            chk_al(1'b1);
            drive(24'h000000);
        end
        // pending write stays inactive until refresh
        step(1);
        host.wr(AEM_REG_ALERT_EN, 24'hFFFFFF);
        rdchk(AEM_REG_ALERT_EN, 24'hFFFFFE);
        drive(24'hFFFFFC);
        chk_al(1'b0);
        host.refresh();
        check("active_mask", active_mask, 24'h000002);
        step(1);
        check("active_mask", active_mask, 24'hFFFFFE);
        step(2);
        chk_al(1'b1);
        load(24'h000000);
        step(2);
        chk_al(1'b0);
        drive(24'h000000);
        // other addresses: write ignored, read answers zero
        host.wr(8'h48, 24'hFFFFFF);
        step(1);
        rdchk(8'h48, 24'h000000);
        step(1);
        rdchk(AEM_REG_ALERT_EN, 24'h000000);
        // write strobe with clock enable low is not taken
        step(1);
        clk_en = 1'b0;
        host.wr(AEM_REG_ALERT_EN, 24'h00F000);
        clk_en = 1'b1;
        step(1);
        rdchk(AEM_REG_ALERT_EN, 24'h000000);
        // consecutive-sample counts, enables cleared while the count changes
        step(1);
        for (int s = 0; s < 4; s++) begin
            load(24'h000000);
            limit_nsel[39:38] = 2'(s);
            load(24'h800000);
            repeat (need_t[s] - 1) drive(24'h800000);
            drive(24'h000000);
            repeat (need_t[s] - 1) drive(24'h800000);
            chk_al(1'b0);
            drive(24'h800000);
            chk_al(1'b1);
            drive(24'h000000);
        end
        // second reset mid-run clears both copies
        sys_rst = 1'b1;
        step(1);
        sys_rst = 1'b0;
        step(1);
        check("active_mask", active_mask, AEM_MASK_RESET);
        rdchk(AEM_REG_ALERT_EN, AEM_MASK_RESET);
        finish_test();
    end
endmodule
`default_nettype wire
